//--- design/mcas_blink.sv
`timescale 1ns/1ns
module mcas_blink
   import mcas_pkg::*;
#(
   parameter int N = 4
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         tick,
   input  wire logic [N-1:0] steady,
   input  wire logic [N-1:0] act,
   output logic      [N-1:0] lamp
);

   logic phase_r;

   // Common blink phase so all lamps flash together
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         phase_r <= 1'b0;
      else if (tick)
         phase_r <= ~phase_r;
   end

   ////////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_lamp
         logic seen_r;
         logic hold_r;

         // Activity is caught in one period and shown in the next
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               seen_r <= 1'b0;
               hold_r <= 1'b0;
            end
            else if (tick)
            begin
               seen_r <= act[i];
               hold_r <= seen_r | act[i];
            end
            else if (act[i])
               seen_r <= 1'b1;
         end

         // Blink while busy, else follow the steady level
         always_ff @(posedge clk)
         begin
            if (!rst_n)
               lamp[i] <= 1'b0;
            else
               lamp[i] <= hold_r ? phase_r : steady[i];
         end
      end
   endgenerate

endmodule

//--- design/mcas_debounce.sv
`timescale 1ns/1ns
module mcas_debounce
   import mcas_pkg::*;
#(
   parameter int               WIDTH      = 1,
   parameter int               STABLE_CYC = 1,
   parameter logic [WIDTH-1:0] RESET_VAL  = '0
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] raw,
   output logic      [WIDTH-1:0] clean
);

   localparam int CW = $clog2(STABLE_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(STABLE_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         logic          meta_r;
         logic          sync_r;
         logic [CW-1:0] cnt_r;

         // Two flops, first read only by second
         always_ff @(posedge clk)
         begin
            meta_r <= raw[i];
            sync_r <= meta_r;
         end

         // New level must hold steady for the full window
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               cnt_r    <= '0;
               clean[i] <= RESET_VAL[i];
            end
            else if (sync_r == clean[i])
               cnt_r <= '0;
            else if (cnt_r == LAST)
            begin
               cnt_r    <= '0;
               clean[i] <= sync_r;
            end
            else
               cnt_r <= cnt_r + 1'b1;
         end
      end
   endgenerate

endmodule

//--- design/mcas_pkg.sv
package mcas_pkg;

   // Core clock
   localparam int CLK_FREQ_HZ     = 100_000_000;

   // Times in their own units
   localparam int DEBOUNCE_MS     = 10;
   localparam int BLINK_MS        = 50;
   localparam int MDIX_MS         = 1;
   localparam int DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_FREQ_HZ / 1000);
   localparam int BLINK_CYC       = BLINK_MS * (CLK_FREQ_HZ / 1000);
   localparam int MDIX_CYC        = MDIX_MS * (CLK_FREQ_HZ / 1000);

   // Register byte offsets
   localparam logic [7:0] OFS_STATE    = 8'h00;
   localparam logic [7:0] OFS_EVENT    = 8'h04;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
   localparam logic [7:0] OFS_NEG_CTRL = 8'h0c;

   // Event bits, shared by event and mask registers
   localparam int EV_SUPPLY_A_LOST  = 0;
   localparam int EV_SUPPLY_B_LOST  = 1;
   localparam int EV_COPPER_DOWN    = 2;
   localparam int EV_OPTICAL_DOWN   = 3;
   localparam int EV_COLLISION      = 4;
   localparam int EV_FAULT          = 5;
   localparam int EV_W              = 6;

   // State register fields
   localparam int ST_SUPPLY_A   = 0;
   localparam int ST_SUPPLY_B   = 1;
   localparam int ST_COPPER_UP  = 2;
   localparam int ST_OPTICAL_UP = 3;
   localparam int ST_SPEED_100  = 4;
   localparam int ST_COPPER_FDX = 5;
   localparam int ST_OPT_FDX    = 6;
   localparam int ST_ALARM_EN   = 7;
   localparam int ST_PAIR_SWAP  = 8;
   localparam int ST_FAULT      = 9;
   localparam int ST_W          = 10;

   // Negotiation control fields
   localparam int NC_ADV_100    = 0;
   localparam int NC_ADV_FDX    = 1;
   localparam int NC_RESTART    = 2;
   localparam logic [1:0] NC_RESET = 2'h3;

   // Switch defaults before sampling
   localparam logic SW_ALARM_DEFAULT = 1'b0;
   localparam logic SW_FDX_DEFAULT   = 1'b1;

   // Copper port negotiation states
   typedef enum logic [1:0] {CU_DOWN, CU_RESOLVE, CU_UP} mcas_cu_e;

endpackage

//--- design/mcas_top.sv
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module mcas_top
   import mcas_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int BLINK_CYCLES    = BLINK_CYC,
   parameter int MDIX_CYCLES     = MDIX_CYC
)
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic             HREADYOUT,
   output logic             HRESP,
   output logic      [31:0] HRDATA,
   output logic             IRQ,
   // Pins from supplies, switches and the two ports
   input  wire logic        SUPPLY_A_PRESENT,
   input  wire logic        SUPPLY_B_PRESENT,
   input  wire logic        SW_PORT_ALARM,
   input  wire logic        SW_OPTICAL_FDX,
   input  wire logic        SW_RESERVED,
   input  wire logic        COPPER_LINK,
   input  wire logic        COPPER_ACTIVITY,
   input  wire logic        COPPER_PARTNER_NEG,
   input  wire logic        COPPER_PARTNER_100,
   input  wire logic        COPPER_PARTNER_FDX,
   input  wire logic        OPTICAL_LINK,
   input  wire logic        OPTICAL_ACTIVITY,
   input  wire logic        OPTICAL_COLLISION,
   // Relay, lamps and port configuration
   output logic             FAULT_RELAY_CLOSED,
   output logic             FAULT_LAMP,
   output logic             SUPPLY_A_INDICATOR,
   output logic             SUPPLY_B_INDICATOR,
   output logic             LOW_SPEED_LAMP,
   output logic             HIGH_SPEED_LAMP,
   output logic             OPTICAL_SPEED_LAMP,
   output logic             DUPLEX_COLLISION_LAMP,
   output logic             COPPER_PAIR_SWAP,
   output logic             COPPER_SPEED_100,
   output logic             COPPER_FULL_DUPLEX,
   output logic             OPTICAL_FULL_DUPLEX
);

   localparam int BW = $clog2(BLINK_CYCLES + 1);
   localparam int MW = $clog2(MDIX_CYCLES + 1);
   localparam int PW = $clog2(DEBOUNCE_CYCLES + 4);
   localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYCLES - 1);
   localparam logic [MW-1:0] MDIX_LAST  = MW'(MDIX_CYCLES - 1);
   localparam logic [PW-1:0] BOOT_LAST  = PW'(DEBOUNCE_CYCLES + 2);

   ////////////////////////////////////////////////////////////////////////
   // Input conditioning
   logic [3:0] slow_q;
   logic [1:0] sw_q;
   logic [2:0] fast_q;
   logic       sup_a;
   logic       sup_b;
   logic       cu_link;
   logic       opt_link;
   logic       cu_act;
   logic       opt_act;
   logic       opt_col;

   // Slow levels filtered so a glitch cannot trip the relay
   mcas_debounce #(
      .WIDTH      (4),
      .STABLE_CYC (DEBOUNCE_CYCLES),
      .RESET_VAL  (4'h3)
   ) u_deb_slow (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .raw   ({OPTICAL_LINK, COPPER_LINK, SUPPLY_B_PRESENT, SUPPLY_A_PRESENT}),
      .clean (slow_q)
   );

   // Switches also settle before they are sampled
   mcas_debounce #(
      .WIDTH      (2),
      .STABLE_CYC (DEBOUNCE_CYCLES),
      .RESET_VAL  ({SW_FDX_DEFAULT, SW_ALARM_DEFAULT})
   ) u_deb_sw (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .raw   ({SW_OPTICAL_FDX, SW_PORT_ALARM}),
      .clean (sw_q)
   );

   // Short activity pulses are only synchronised
   mcas_debounce #(
      .WIDTH      (3),
      .STABLE_CYC (1),
      .RESET_VAL  (3'h0)
   ) u_sync_fast (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .raw   ({OPTICAL_COLLISION, OPTICAL_ACTIVITY, COPPER_ACTIVITY}),
      .clean (fast_q)
   );

   assign sup_a    = slow_q[0];
   assign sup_b    = slow_q[1];
   assign cu_link  = slow_q[2];
   assign opt_link = slow_q[3];
   assign cu_act   = fast_q[0];
   assign opt_act  = fast_q[1];
   assign opt_col  = fast_q[2];

   ////////////////////////////////////////////////////////////////////////
   // Power-up switch capture; the reserved switch has no reader
   logic [PW-1:0] boot_cnt_r;
   logic          sw_taken_r;
   logic          alarm_en_r;
   logic          opt_fdx_r;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         boot_cnt_r <= '0;
         sw_taken_r <= 1'b0;
         alarm_en_r <= SW_ALARM_DEFAULT;
         opt_fdx_r  <= SW_FDX_DEFAULT;
      end
      else if (!sw_taken_r)
      begin
         boot_cnt_r <= boot_cnt_r + 1'b1;
         if (boot_cnt_r == BOOT_LAST)
         begin
            sw_taken_r <= 1'b1;
            alarm_en_r <= sw_q[0];
            opt_fdx_r  <= sw_q[1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Divided enables for blinking and crossover hunting
   logic [BW-1:0] blink_cnt_r;
   logic [MW-1:0] mdix_cnt_r;
   logic          blink_tick;
   logic          mdix_tick;

   assign blink_tick = (blink_cnt_r == BLINK_LAST);
   assign mdix_tick  = (mdix_cnt_r == MDIX_LAST);

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         blink_cnt_r <= '0;
         mdix_cnt_r  <= '0;
      end
      else
      begin
         blink_cnt_r <= blink_tick ? '0 : blink_cnt_r + 1'b1;
         mdix_cnt_r  <= mdix_tick ? '0 : mdix_cnt_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Copper negotiation and crossover
   mcas_cu_e cu_state_r;
   logic     swap_r;
   logic     speed100_r;
   logic     cu_fdx_r;
   logic     adv100_r;
   logic     advfdx_r;
   logic     restart;
   logic     cu_up;

   assign cu_up = (cu_state_r == CU_UP);

   // Pairs flip while idle until the partner is heard; kept once up
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         cu_state_r <= CU_DOWN;
         swap_r     <= 1'b0;
         speed100_r <= 1'b0;
         cu_fdx_r   <= 1'b0;
      end
      else
      begin
         case (cu_state_r)
            CU_DOWN:
            begin
               speed100_r <= 1'b0;
               cu_fdx_r   <= 1'b0;
               if (cu_link)
                  cu_state_r <= CU_RESOLVE;
               else if (mdix_tick)
                  swap_r <= ~swap_r;
            end
            CU_RESOLVE:
            begin
               cu_state_r <= CU_UP;
               if (COPPER_PARTNER_NEG)
               begin
                  speed100_r <= adv100_r & COPPER_PARTNER_100;
                  cu_fdx_r   <= advfdx_r & COPPER_PARTNER_FDX;
               end
               else
               begin
                  speed100_r <= 1'b0;
                  cu_fdx_r   <= 1'b0;
               end
            end
            CU_UP:
            begin
               if (!cu_link || restart)
                  cu_state_r <= CU_DOWN;
            end
            default:
               cu_state_r <= CU_DOWN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault relay and fault lamp
   logic port_fail;
   logic fault;
   logic fault_r;

   // A disabled alarm keeps link loss off the relay and fault lamp; link-down events are still recorded
   assign port_fail = alarm_en_r & (~cu_up | ~opt_link);
   assign fault     = ~sup_a | ~sup_b | port_fail;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         fault_r            <= 1'b0;
         FAULT_RELAY_CLOSED <= 1'b0;
         FAULT_LAMP         <= 1'b0;
      end
      else
      begin
         fault_r            <= fault;
         FAULT_RELAY_CLOSED <= ~fault;
         FAULT_LAMP         <= port_fail;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lamps
   logic [3:0] lamp_q;

   mcas_blink #(
      .N (4)
   ) u_blink (
      .clk    (CORE_CLK),
      .rst_n  (RST_N),
      .tick   (blink_tick),
      .steady ({opt_fdx_r, opt_link, cu_up & speed100_r, cu_up & ~speed100_r}),
      .act    ({opt_col & opt_link, opt_act & opt_link,
                cu_act & cu_up & speed100_r, cu_act & cu_up & ~speed100_r}),
      .lamp   (lamp_q)
   );

   assign LOW_SPEED_LAMP        = lamp_q[0];
   assign HIGH_SPEED_LAMP       = lamp_q[1];
   assign OPTICAL_SPEED_LAMP    = lamp_q[2];
   assign DUPLEX_COLLISION_LAMP = lamp_q[3];
   assign SUPPLY_A_INDICATOR    = sup_a;
   assign SUPPLY_B_INDICATOR    = sup_b;
   assign COPPER_PAIR_SWAP      = swap_r;
   assign COPPER_SPEED_100      = speed100_r;
   assign COPPER_FULL_DUPLEX    = cu_fdx_r;
   assign OPTICAL_FULL_DUPLEX   = opt_fdx_r;

   ////////////////////////////////////////////////////////////////////////
   // Event detection; falling supply and link levels and rising collision and fault are the alarming edges
   logic [EV_W-1:0] ev_prev_r;
   logic [EV_W-1:0] ev_level;
   logic [EV_W-1:0] ev_hit;

   assign ev_level = {fault_r, opt_col, ~opt_link, ~cu_up, ~sup_b, ~sup_a};
   assign ev_hit   = ev_level & ~ev_prev_r;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         ev_prev_r <= '0;
      else
         ev_prev_r <= ev_level;
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, always OKAY
   logic            ap_valid;
   logic            wr_pend_r;
   logic [7:0]      wr_addr_r;
   logic            wr_event;
   logic            wr_mask;
   logic            wr_neg;
   logic [EV_W-1:0] event_r;
   logic [EV_W-1:0] mask_r;
   logic [ST_W-1:0] state_word;
   logic [31:0]     rd_mux;

   assign ap_valid  = HSEL & HTRANS[1] & HREADY;
   assign wr_event  = wr_pend_r & (wr_addr_r == OFS_EVENT);
   assign wr_mask   = wr_pend_r & (wr_addr_r == OFS_IRQ_MASK);
   assign wr_neg    = wr_pend_r & (wr_addr_r == OFS_NEG_CTRL);
   assign restart   = wr_neg & HWDATA[NC_RESTART];
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign IRQ       = |(event_r & mask_r);

   assign state_word = {fault_r, swap_r, alarm_en_r, opt_fdx_r, cu_fdx_r,
                        speed100_r, opt_link, cu_up, sup_b, sup_a};

   // Unmapped offsets read as zero
   assign rd_mux =
      (HADDR[7:0] == OFS_STATE)    ? {{(32-ST_W){1'b0}}, state_word} :
      (HADDR[7:0] == OFS_EVENT)    ? {{(32-EV_W){1'b0}}, event_r} :
      (HADDR[7:0] == OFS_IRQ_MASK) ? {{(32-EV_W){1'b0}}, mask_r} :
      (HADDR[7:0] == OFS_NEG_CTRL) ? {30'h0, advfdx_r, adv100_r} :
      32'h0;

   // Address phase captured; read data prepared for the data phase
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
         HRDATA    <= '0;
      end
      else
      begin
         wr_pend_r <= ap_valid & HWRITE;
         wr_addr_r <= HADDR[7:0];
         if (ap_valid && !HWRITE)
            HRDATA <= rd_mux;
      end
   end

   // Sticky events; a new event beats a simultaneous clear
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         event_r <= '0;
      else
         event_r <= (event_r & ~(wr_event ? HWDATA[EV_W-1:0] : '0)) | ev_hit;
   end

   // Mask and advertisement registers
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         mask_r   <= '0;
         adv100_r <= NC_RESET[NC_ADV_100];
         advfdx_r <= NC_RESET[NC_ADV_FDX];
      end
      else
      begin
         if (wr_mask)
            mask_r <= HWDATA[EV_W-1:0];
         if (wr_neg)
         begin
            adv100_r <= HWDATA[NC_ADV_100];
            advfdx_r <= HWDATA[NC_ADV_FDX];
         end
      end
   end

endmodule

//--- tb/mcas_partner.sv
`timescale 1ns/1ns
module mcas_partner
(
   input  wire logic clk,
   input  wire logic cu_up,
   input  wire logic cu_neg,
   input  wire logic cu_100,
   input  wire logic cu_fdx,
   input  wire logic cu_busy,
   input  wire logic fx_up,
   input  wire logic fx_busy,
   input  wire logic fx_col,
   input  wire logic relay_closed,
   output logic      copper_link,
   output logic      copper_act,
   output logic      peer_neg,
   output logic      peer_100,
   output logic      peer_fdx,
   output logic      optical_link,
   output logic      optical_act,
   output logic      optical_col,
   output logic      warn_light
);
   // Quiet, unlinked far ends at power-up
   initial
   begin
      {copper_link, copper_act, peer_neg, peer_100, peer_fdx} = 5'h00;
      {optical_link, optical_act, optical_col} = 3'h0;
   end

   // Pins move just after the edge; traffic shows as one-cycle pulses
   always @(posedge clk)
   begin
      copper_link  <= cu_up;
      copper_act   <= cu_busy & ~copper_act;
      peer_neg     <= cu_neg;
      peer_100     <= cu_neg ? cu_100 : ~peer_100;
      peer_fdx     <= cu_neg ? cu_fdx : ~peer_fdx;
      optical_link <= fx_up;
      optical_act  <= fx_busy & ~optical_act;
      optical_col  <= fx_col & ~optical_col;
   end

   // Control-room lamp lights while the fault loop is open
   assign warn_light = !relay_closed;
endmodule

//--- tb/mcas_top_chk.sv
`timescale 1ns/1ns
module mcas_top_chk
#(
   parameter int DEBOUNCE_CYCLES = 4
)
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic SUPPLY_A_PRESENT,
   input wire logic SUPPLY_B_PRESENT,
   input wire logic COPPER_LINK,
   input wire logic OPTICAL_LINK,
   input wire logic FAULT_RELAY_CLOSED,
   input wire logic FAULT_LAMP,
   input wire logic SUPPLY_A_INDICATOR,
   input wire logic SUPPLY_B_INDICATOR,
   input wire logic LOW_SPEED_LAMP,
   input wire logic HIGH_SPEED_LAMP,
   input wire logic OPTICAL_SPEED_LAMP,
   input wire logic OPTICAL_FULL_DUPLEX
);
   int unsigned age_r;

   // Edges since reset, saturating so it never wraps
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         age_r <= 0;
      else if (age_r < 1000)
         age_r <= age_r + 1;
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   ////////////////////////////////////////////////////////////////////////////////
   property p_sup_loss;
      $fell(SUPPLY_A_INDICATOR) || $fell(SUPPLY_B_INDICATOR) |-> ##[0:2] !FAULT_RELAY_CLOSED;
   endproperty
   a_sup_loss: assert property (p_sup_loss)
      else $error("relay stayed closed after supply loss");
   property p_ok_closed;
      (SUPPLY_A_INDICATOR && SUPPLY_B_INDICATOR && !FAULT_LAMP)[*3] |-> FAULT_RELAY_CLOSED;
   endproperty
   a_ok_closed: assert property (p_ok_closed)
      else $error("relay open with no fault");
   property p_lamp_open;
      FAULT_LAMP |-> !FAULT_RELAY_CLOSED;
   endproperty
   a_lamp_open: assert property (p_lamp_open)
      else $error("fault lamp lit with relay closed");
   property p_sup_on;
      SUPPLY_A_PRESENT[*8] |-> ##1 SUPPLY_A_INDICATOR;
   endproperty
   a_sup_on: assert property (p_sup_on)
      else $error("supply indicator dark with supply");
   property p_sup_off;
      (!SUPPLY_B_PRESENT)[*8] |-> ##1 !SUPPLY_B_INDICATOR;
   endproperty
   a_sup_off: assert property (p_sup_off)
      else $error("supply indicator lit without supply");
   // A fresh drop must not reach the lamp before the debounce window
   property p_glitch;
      SUPPLY_A_PRESENT[*8] ##1 !SUPPLY_A_PRESENT |-> SUPPLY_A_INDICATOR[*4];
   endproperty
   a_glitch: assert property (p_glitch)
      else $error("supply indicator reacted inside debounce window");
   property p_sw_hold;
      age_r > DEBOUNCE_CYCLES + 5 |-> $stable(OPTICAL_FULL_DUPLEX);
   endproperty
   a_sw_hold: assert property (p_sw_hold)
      else $error("duplex switch taken after power-up");
   property p_fx_dark;
      (!OPTICAL_LINK)[*8] |-> ##3 !OPTICAL_SPEED_LAMP;
   endproperty
   a_fx_dark: assert property (p_fx_dark)
      else $error("optical lamp lit without link");
   property p_cu_dark;
      (!COPPER_LINK)[*8] |-> ##3 !(LOW_SPEED_LAMP || HIGH_SPEED_LAMP);
   endproperty
   a_cu_dark: assert property (p_cu_dark)
      else $error("copper lamp lit without link");
endmodule

bind mcas_top mcas_top_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_mcas_top_chk
(
   .CORE_CLK           (CORE_CLK),
   .RST_N              (RST_N),
   .SUPPLY_A_PRESENT   (SUPPLY_A_PRESENT),
   .SUPPLY_B_PRESENT   (SUPPLY_B_PRESENT),
   .COPPER_LINK        (COPPER_LINK),
   .OPTICAL_LINK       (OPTICAL_LINK),
   .FAULT_RELAY_CLOSED (FAULT_RELAY_CLOSED),
   .FAULT_LAMP         (FAULT_LAMP),
   .SUPPLY_A_INDICATOR (SUPPLY_A_INDICATOR),
   .SUPPLY_B_INDICATOR (SUPPLY_B_INDICATOR),
   .LOW_SPEED_LAMP     (LOW_SPEED_LAMP),
   .HIGH_SPEED_LAMP    (HIGH_SPEED_LAMP),
   .OPTICAL_SPEED_LAMP (OPTICAL_SPEED_LAMP),
   .OPTICAL_FULL_DUPLEX(OPTICAL_FULL_DUPLEX)
);

//--- tb/tb_mcas_top.sv
`timescale 1ns/1ns
module tb_mcas_top
   import mcas_pkg::*;
;
   localparam int ST = 24;
   logic clk, rst_n, hsel, hwrite, hrdy, hresp, irq, sa, sb, swa, swf, swr;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic cu_up, cu_neg, cu_busy, fx_up, fx_busy, fx_col, warn;
   logic cl, ca, pn, p1, pf, fl, fa, fc;
   logic relay, flamp, ia, ib, lo, hi, fxl, dcl, swap, s100, cfdx, ofdx;
   int   num_errors, checks;

   mcas_top #(.DEBOUNCE_CYCLES(4), .BLINK_CYCLES(8), .MDIX_CYCLES(16)) u_mcas_top
   (
      .CORE_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy),
      .HREADYOUT(hrdy), .HRESP(hresp), .HRDATA(hrdata), .IRQ(irq),
      .SUPPLY_A_PRESENT(sa), .SUPPLY_B_PRESENT(sb), .SW_PORT_ALARM(swa),
      .SW_OPTICAL_FDX(swf), .SW_RESERVED(swr), .COPPER_LINK(cl), .COPPER_ACTIVITY(ca),
      .COPPER_PARTNER_NEG(pn), .COPPER_PARTNER_100(p1), .COPPER_PARTNER_FDX(pf),
      .OPTICAL_LINK(fl), .OPTICAL_ACTIVITY(fa), .OPTICAL_COLLISION(fc),
      .FAULT_RELAY_CLOSED(relay), .FAULT_LAMP(flamp), .SUPPLY_A_INDICATOR(ia),
      .SUPPLY_B_INDICATOR(ib), .LOW_SPEED_LAMP(lo), .HIGH_SPEED_LAMP(hi),
      .OPTICAL_SPEED_LAMP(fxl), .DUPLEX_COLLISION_LAMP(dcl), .COPPER_PAIR_SWAP(swap),
      .COPPER_SPEED_100(s100), .COPPER_FULL_DUPLEX(cfdx), .OPTICAL_FULL_DUPLEX(ofdx)
   );

   mcas_partner u_mcas_partner
   (
      .clk(clk), .cu_up(cu_up), .cu_neg(cu_neg), .cu_100(1'b1), .cu_fdx(1'b1),
      .cu_busy(cu_busy), .fx_up(fx_up), .fx_busy(fx_busy), .fx_col(fx_col),
      .relay_closed(relay), .copper_link(cl), .copper_act(ca), .peer_neg(pn),
      .peer_100(p1), .peer_fdx(pf), .optical_link(fl), .optical_act(fa),
      .optical_col(fc), .warn_light(warn)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // 100 MHz core clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Bounded wait for the slave; a stuck bus ends the run
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge clk);
      while (hrdy !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            num_errors++;
            report_and_stop();
         end
         @(posedge clk);
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic do_reset;
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_boot;
      cyc(2 * ST);
      chk("relay", 1, relay);
      chk("sup_a", 1, ia);
      chk("ofdx", 1, ofdx);
      chk("dcl", 1, dcl);
      chk("hi", 1, hi);
      chk("lo", 0, lo);
      chk("fxl", 1, fxl);
      chk("neg", 2'h3, {s100, cfdx});
      ahb(1'b0, OFS_IRQ_MASK, 32'h0);
      chk("mask", 0, rd);
      ahb(1'b0, OFS_NEG_CTRL, 32'h0);
      chk("negctl", 3, rd);
      ahb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 0, rd);
      chk("hresp", 0, hresp);
      ahb(1'b1, OFS_NEG_CTRL, 32'h6);
      cyc(4);
      chk("restart", 1, {s100, cfdx});
   endtask

   // Copper loss with alarm off; pairs hunt while down
   task automatic t_copper_drop;
      logic s0;
      int   t;
      cu_up <= 1'b0;
      cyc(ST);
      chk("relay", 1, relay);
      chk("flamp", 0, flamp);
      chk("hi", 0, hi);
      s0 = swap;
      t = 0;
      repeat (36)
      begin
         @(posedge clk);
         t += (swap !== s0);
         s0 = swap;
      end
      chk("swap_toggles", 1, t >= 1);
      cu_up <= 1'b1;
      cyc(2 * ST);
   endtask

   task automatic t_supply_irq;
      ahb(1'b1, OFS_EVENT, 32'h3f);
      ahb(1'b1, OFS_IRQ_MASK, 32'h1 << EV_SUPPLY_A_LOST);
      sa <= 1'b0;
      cyc(ST);
      chk("sup_a", 0, ia);
      chk("relay", 0, relay);
      chk("warn", 1, warn);
      chk("irq", 1, irq);
      sa <= 1'b1;
      cyc(ST);
      chk("relay", 1, relay);
      ahb(1'b1, OFS_IRQ_MASK, 32'h0);
      cyc(1);
      chk("irq_masked", 0, irq);
      ahb(1'b1, OFS_IRQ_MASK, 32'h1 << EV_SUPPLY_A_LOST);
      ahb(1'b0, OFS_EVENT, 32'h0);
      chk("ev_a", 1, rd[EV_SUPPLY_A_LOST]);
      ahb(1'b1, OFS_EVENT, 32'h1 << EV_SUPPLY_A_LOST);
      cyc(2);
      chk("irq_clr", 0, irq);
   endtask

   task automatic t_glitch;
      sb <= 1'b0;
      cyc(2);
      sb <= 1'b1;
      cyc(ST);
      chk("sup_b", 1, ib);
      chk("relay", 1, relay);
   endtask

   task automatic t_late_switch;
      swa <= 1'b1;
      swf <= 1'b0;
      swr <= 1'b0;
      cyc(ST);
      chk("ofdx", 1, ofdx);
      chk("dcl", 1, dcl);
   endtask

   // Power cycle: new switches, non-negotiating copper peer
   task automatic t_cycle;
      cu_neg <= 1'b0;
      do_reset();
      cyc(2 * ST);
      chk("ofdx", 0, ofdx);
      chk("dcl", 0, dcl);
      chk("neg", 0, {s100, cfdx});
      chk("lo", 1, lo);
      chk("relay", 1, relay);
   endtask

   task automatic t_port_alarm;
      fx_up <= 1'b0;
      cyc(ST);
      chk("relay", 0, relay);
      chk("flamp", 1, flamp);
      chk("fxl", 0, fxl);
      fx_up <= 1'b1;
      cyc(ST);
      chk("flamp", 0, flamp);
   endtask

   // Traffic and collisions must make the lamps change
   task automatic t_blink;
      logic [2:0] prev, tog;
      tog = 3'h0;
      cu_busy <= 1'b1;
      fx_busy <= 1'b1;
      fx_col  <= 1'b1;
      prev = {lo, fxl, dcl};
      repeat (48)
      begin
         @(posedge clk);
         tog |= prev ^ {lo, fxl, dcl};
         prev = {lo, fxl, dcl};
      end
      chk("lo_blink", 1, tog[2]);
      chk("fxl_blink", 1, tog[1]);
      chk("dcl_blink", 1, tog[0]);
      cu_busy <= 1'b0;
      fx_busy <= 1'b0;
      fx_col  <= 1'b0;
      cyc(ST);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      num_errors = 0;
      checks = 0;
      {rst_n, hsel, hwrite, haddr, hwdata, htrans, hsize} = {3'h0, 64'h0, 2'h0, 3'h2};
      {sa, sb, swa, swf, swr} = 5'b11011;
      {cu_up, cu_neg, cu_busy, fx_up, fx_busy, fx_col} = 6'b110100;
      do_reset();
      t_boot();
      t_copper_drop();
      t_supply_irq();
      t_glitch();
      t_late_switch();
      t_cycle();
      t_port_alarm();
      t_blink();
      report_and_stop();
   end
endmodule
